// [hdl/bsr_params.svh]
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH
// ==========================================================================
// register indices (byte address is four times the index)
`define BSR_IDX_CFG      8'h2F
`define BSR_IDX_STATUS   8'h30
`define BSR_IDX_PACE1    8'h31
`define BSR_IDX_PACE2    8'h33
`define BSR_IDX_PACE3    8'h35
`define BSR_IDX_ECG1     8'h37
`define BSR_IDX_ECG2     8'h3A
`define BSR_IDX_ECG3     8'h3D
`define BSR_IDX_LAST     8'h3F
`define BSR_IDX_REV      8'h40
`define BSR_IDX_LOOP     8'h50
`define BSR_IDX_IRQ_ST   8'h60
`define BSR_IDX_IRQ_MSK  8'h61
// ==========================================================================
// field positions and reset values
`define BSR_CFG_STS_BIT  0
`define BSR_CFG_PACE_LSB 1
`define BSR_CFG_ECG_LSB  4
`define BSR_STS_ALARM    1
`define BSR_CFG_RESET    7'h00
`define BSR_IRQ_RESET    6'h00
`define BSR_REV_DEFAULT  8'hA5
`endif

// [hdl/bsr_pkg.sv]
package bsr_pkg;
  // ========================================================================
  // types
  typedef logic [7:0] bsr_byte_t;

  // new samples from the conversion path, one pace and one ECG strobe per channel
  typedef struct packed {
    logic [2:0]       pace_valid;
    logic [2:0][15:0] pace;
    logic [2:0]       ecg_valid;
    logic [2:0][23:0] ecg;
  } bsr_sample_s;

  // whole state of the read-back bank
  typedef struct packed {
    logic [6:0]       cfg;
    logic [5:0]       drdy;
    logic [2:0][15:0] pace;
    logic [2:0][23:0] ecg;
    logic [3:0]       ptr;
    logic [3:0]       ridx;
    logic [5:0]       irq_st;
    logic [5:0]       irq_msk;
    logic             waitrequest;
    logic [31:0]      readdata;
    logic             irq;
    logic             alarm_out_n;
  } bsr_state_s;
endpackage

// [hdl/bsr_readback.sv]
// Functional notes
// - channel 1 pace sample: upper byte at 0x31, lower byte at 0x32
// - channel 2 pace sample: upper byte 0x33, lower byte 0x34, read-only
// - channel 3 pace sample: upper byte 0x35, lower byte 0x36, read-only
// - channel 1 ECG sample: upper, middle, lower at 0x37, 0x38, 0x39
// - channel 2 ECG sample: upper, middle, lower at 0x3A, 0x3B, 0x3C
// - channel 3 ECG sample: upper, middle, lower at 0x3D, 0x3E, 0x3F
// - fixed 8-bit revision code at 0x40, writes have no effect
// - address 0x50 returns bytes drawn from registers 0x30 to 0x3F
// - loop read-back returns only groups enabled in the select register
// - select bits: 6..4 ECG 3..1, 3..1 pace 3..1, 0 status; reset 0
// - status: bits 7..2 data ready, bit 1 alarm, bit 0 reads zero
`include "bsr_params.svh"
`timescale 1ns/1ns
`default_nettype none

module bsr_readback
  import bsr_pkg::*;
#(
  parameter bsr_byte_t REVISION = `BSR_REV_DEFAULT // arbitrary value
)(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // conversion path and alarm logic
  input  wire bsr_sample_s sample,
  input  wire logic        alarm_active,
  // outputs
  output logic             alarm_out_n,
  output logic             irq
);

  // ========================================================================
  // helpers

  // first enabled byte at or after start, circular; start if none enabled
  function automatic logic [3:0] first_en(input logic [15:0] mask,
                                          input logic [3:0]  start);
    logic [3:0] r;
    logic [3:0] j;
    logic       f;
    r = start;
    f = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      j = start + i[3:0];
      if (!f && mask[j])
      begin
        r = j;
        f = 1'b1;
      end
    end
    return r;
  endfunction

  // ========================================================================
  // state and decode
  bsr_state_s q;
  bsr_state_s next_q;
  logic [7:0]      idx;
  logic            taken;
  logic            in_win;
  logic [15:0]     en;
  bsr_byte_t       img [16];
  logic [3:0]      loop_cur;
  logic [3:0]      rd_sel;
  logic            rd_hit;
  logic [5:0]      drdy_set;
  logic [5:0]      drdy_clr;

  // request accepted at the edge where waitrequest is low
  assign idx      = address[9:2];
  assign taken    = (read || write) && !q.waitrequest;
  assign in_win   = (idx >= `BSR_IDX_STATUS) && (idx <= `BSR_IDX_LAST);
  assign drdy_set = {sample.ecg_valid, sample.pace_valid};
  assign loop_cur = first_en(en, q.ptr);

  // byte image of 0x30..0x3F and its read-back enables
  assign en[0]  = q.cfg[`BSR_CFG_STS_BIT];
  assign img[0] = {q.drdy, ~q.alarm_out_n, 1'b0};
  genvar n;
  generate
    for (n = 0; n < 3; n++)
    begin : g_chan
      assign en[1 + 2*n]  = q.cfg[`BSR_CFG_PACE_LSB + n];
      assign en[2 + 2*n]  = q.cfg[`BSR_CFG_PACE_LSB + n];
      assign en[7 + 3*n]  = q.cfg[`BSR_CFG_ECG_LSB + n];
      assign en[8 + 3*n]  = q.cfg[`BSR_CFG_ECG_LSB + n];
      assign en[9 + 3*n]  = q.cfg[`BSR_CFG_ECG_LSB + n];
      // upper byte at the lower address
      assign img[1 + 2*n] = q.pace[n][15:8];
      assign img[2 + 2*n] = q.pace[n][7:0];
      assign img[7 + 3*n] = q.ecg[n][23:16];
      assign img[8 + 3*n] = q.ecg[n][15:8];
      assign img[9 + 3*n] = q.ecg[n][7:0];
      // a group's ready flag drops once its last byte is read
      assign drdy_clr[n]     = rd_hit && (rd_sel == 4'(2 + 2*n));
      assign drdy_clr[3 + n] = rd_hit && (rd_sel == 4'(9 + 3*n));
    end
  endgenerate

  // byte selected by the current read, direct or through the loop port
  always_comb
  begin
    rd_sel = idx[3:0];
    rd_hit = 1'b0;
    if (read && in_win)
    begin
      rd_hit = taken;
    end
    else if (read && idx == `BSR_IDX_LOOP)
    begin
      rd_sel = loop_cur;
      rd_hit = taken && (|en);
    end
  end

  // ========================================================================
  // next state
  always_comb
  begin
    next_q = q;
    // samples replace the held value as they arrive
    for (int c = 0; c < 3; c++)
    begin
      if (sample.pace_valid[c])
      begin
        next_q.pace[c] = sample.pace[c];
      end
      if (sample.ecg_valid[c])
      begin
        next_q.ecg[c] = sample.ecg[c];
      end
    end
    // set wins over the clear by a read in the same cycle
    next_q.drdy        = (q.drdy & ~drdy_clr) | drdy_set;
    next_q.alarm_out_n = !alarm_active;
    // one wait cycle, then the request is taken
    next_q.waitrequest = !((read || write) && q.waitrequest);
    // read data are prepared during the wait cycle
    if (read && q.waitrequest)
    begin
      next_q.readdata = 32'h0000_0000;
      next_q.ridx     = rd_sel;
      if (in_win)
      begin
        next_q.readdata[7:0] = img[idx[3:0]];
      end
      else
      begin
        unique case (idx)
          `BSR_IDX_CFG:     next_q.readdata[6:0] = q.cfg;
          `BSR_IDX_REV:     next_q.readdata[7:0] = REVISION;
          `BSR_IDX_LOOP:
          begin
            // nothing enabled: the loop port reads as zero
            if (|en)
            begin
              next_q.readdata[7:0] = img[loop_cur];
            end
          end
          `BSR_IDX_IRQ_ST:  next_q.readdata[5:0] = q.irq_st;
          `BSR_IDX_IRQ_MSK: next_q.readdata[5:0] = q.irq_msk;
          default:          next_q.readdata = 32'h0000_0000;
        endcase
      end
    end
    // loop pointer: advance after a loop read, restart on any other access
    if (taken)
    begin
      if (read && idx == `BSR_IDX_LOOP)
      begin
        if (|en)
        begin
          next_q.ptr = loop_cur + 4'h1;
        end
      end
      else
      begin
        next_q.ptr = 4'h0;
      end
    end
    // writes: only the select, interrupt status and mask registers take data
    if (taken && write && byteenable[0])
    begin
      unique case (idx)
        `BSR_IDX_CFG:     next_q.cfg = writedata[6:0];
        `BSR_IDX_IRQ_ST:  next_q.irq_st = q.irq_st & ~writedata[5:0];
        `BSR_IDX_IRQ_MSK: next_q.irq_msk = writedata[5:0];
        default:          next_q.cfg = q.cfg;
      endcase
    end
    // new data events are sticky; setting beats a clear in the same cycle
    next_q.irq_st = next_q.irq_st | drdy_set;
    next_q.irq    = |(next_q.irq_st & next_q.irq_msk);
  end

  // ========================================================================
  // state register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q             <= '0;
      q.cfg         <= `BSR_CFG_RESET;
      q.irq_st      <= `BSR_IRQ_RESET;
      q.irq_msk     <= `BSR_IRQ_RESET;
      q.waitrequest <= 1'b1;
      q.alarm_out_n <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign readdata    = q.readdata;
  assign waitrequest = q.waitrequest;
  assign irq         = q.irq;
  assign alarm_out_n = q.alarm_out_n;

  // ========================================================================
  // assertions
  a_pace1_upper: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_PACE1)
      |-> readdata[7:0] == $past(q.pace[0][15:8]))
    else $error("channel 1 pace upper byte wrong");

  a_pace2_lower: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_PACE2 + 8'h01)
      |-> readdata[7:0] == $past(q.pace[1][7:0]))
    else $error("channel 2 pace lower byte wrong");

  a_pace3_upper: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_PACE3)
      |-> readdata[7:0] == $past(q.pace[2][15:8]))
    else $error("channel 3 pace upper byte wrong");

  a_ecg1_middle: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_ECG1 + 8'h01)
      |-> readdata[7:0] == $past(q.ecg[0][15:8]))
    else $error("channel 1 ECG middle byte wrong");

  a_ecg2_lower: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_ECG2 + 8'h02)
      |-> readdata[7:0] == $past(q.ecg[1][7:0]))
    else $error("channel 2 ECG lower byte wrong");

  a_ecg3_upper: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_ECG3)
      |-> readdata[7:0] == $past(q.ecg[2][23:16]))
    else $error("channel 3 ECG upper byte wrong");

  a_pace1_lower: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_PACE1 + 8'h01)
      |-> readdata[7:0] == $past(q.pace[0][7:0]))
    else $error("channel 1 pace lower byte wrong");

  a_pace2_upper: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_PACE2)
      |-> readdata[7:0] == $past(q.pace[1][15:8]))
    else $error("channel 2 pace upper byte wrong");

  a_pace3_lower: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_PACE3 + 8'h01)
      |-> readdata[7:0] == $past(q.pace[2][7:0]))
    else $error("channel 3 pace lower byte wrong");

  a_ecg1_upper: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_ECG1)
      |-> readdata[7:0] == $past(q.ecg[0][23:16]))
    else $error("channel 1 ECG upper byte wrong");

  a_ecg1_lower: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_ECG1 + 8'h02)
      |-> readdata[7:0] == $past(q.ecg[0][7:0]))
    else $error("channel 1 ECG lower byte wrong");

  a_ecg2_upper: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_ECG2)
      |-> readdata[7:0] == $past(q.ecg[1][23:16]))
    else $error("channel 2 ECG upper byte wrong");

  a_ecg3_lower: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_ECG3 + 8'h02)
      |-> readdata[7:0] == $past(q.ecg[2][7:0]))
    else $error("channel 3 ECG lower byte wrong");

  a_rev_fixed: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_REV)
      |-> readdata == {24'h00_0000, REVISION})
    else $error("revision code wrong");

  a_loop_empty: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_LOOP && q.cfg == 7'h00
      && $past(q.cfg) == 7'h00) |-> readdata == 32'h0000_0000)
    else $error("loop port returned data with nothing enabled");

  a_loop_enabled: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_LOOP && (|en)
      && $stable(q.cfg)) |-> en[q.ridx])
    else $error("loop port returned a disabled register");

  a_cfg_write: assert property (@(posedge mclk) disable iff (!rstn)
    (write && !waitrequest && idx == `BSR_IDX_CFG && byteenable[0])
      |=> q.cfg == $past(writedata[6:0]))
    else $error("select register did not take the write");

  a_status_bits: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_STATUS)
      |-> readdata[0] == 1'b0
          && readdata[`BSR_STS_ALARM] == !$past(alarm_out_n))
    else $error("status alarm or zero bit wrong");

  a_loop_step: assert property (@(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == `BSR_IDX_LOOP && (|en))
      |=> q.ptr == $past(q.ridx) + 4'h1)
    else $error("loop pointer did not step past the byte read");

  a_wait_one: assert property (@(posedge mclk) disable iff (!rstn)
    (read && $rose(read)) |=> !waitrequest)
    else $error("read not answered after one wait cycle");

  a_ready_set: assert property (@(posedge mclk) disable iff (!rstn)
    (drdy_set != 6'h00)
      |=> (q.drdy & $past(drdy_set)) == $past(drdy_set))
    else $error("data ready flag not set by a new sample");

  a_wait_low: assert property (@(posedge mclk) disable iff (!rstn)
    !waitrequest |=> waitrequest)
    else $error("waitrequest stayed low for more than one cycle");

endmodule // bsr_readback

`default_nettype wire

// [dv/bsr_host.sv]
`timescale 1ns/1ns
`default_nettype none

module bsr_host (
  // clock
  input  wire logic        mclk,
  // avalon-mm master side
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [9:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable
);
  // ========================================================================
  // idle bus at time zero
  initial
  begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'hF;
  end

  // one transfer; an edge always passes first so strobes never toggle twice
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd, input logic [3:0] be,
                      output logic [31:0] rd);
    @(posedge mclk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h00_0000, wd};
    byteenable <= be;
    // no cycle count assumed; the bench timeout cuts a hang
    do @(posedge mclk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule // bsr_host

`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ns
`default_nettype none

module testbench import bsr_pkg::*;;
  // ========================================================================
  // design hookup
  localparam logic [7:0] REV_CODE = 8'h5C; // arbitrary value
  logic mclk = 1'b0, rstn = 1'b0, alarm_active = 1'b0;
  logic [9:0] address;
  logic read, write, waitrequest, irq, alarm_out_n;
  logic [31:0] writedata, readdata, got;
  logic [3:0] byteenable;
  bsr_sample_s smp = '0;
  int fail_count = 0, checks_done = 0, cyc = 0, seed = 32'hd6b1;
  int cfg = 0, drdy = 0, ist = 0, msk = 0, ptr = 'h30, alm = 0;
  int pace[3] = '{0, 0, 0}, ecg[3] = '{0, 0, 0};
  int vals[6] = '{'h7F, 'h30, 'h0B, 'h01, 'h00, 'h54};

  bsr_readback #(.REVISION(REV_CODE)) u_bsr_readback (.mclk(mclk),
    .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sample(smp), .alarm_active(alarm_active),
    .alarm_out_n(alarm_out_n), .irq(irq));
  bsr_host u_bsr_host (.mclk(mclk), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable));

  // 50 MHz clock
  always #10 mclk = ~mclk;

  // ========================================================================
  // reference model of the register bank
  function automatic int grp(int i);
    if (i == 'h30) return 0;
    if (i < 'h37) return 1 + (i - 'h31) / 2;
    return 4 + (i - 'h37) / 3;
  endfunction

  function automatic int reg_val(int i);
    if (i == 'h2F) return cfg;
    if (i == 'h30) return (drdy << 2) | (alm << 1);
    if (i >= 'h31 && i <= 'h36)
      return (pace[(i - 'h31) / 2] >> (8 * (1 - (i - 'h31) % 2))) & 255;
    if (i >= 'h37 && i <= 'h3F)
      return (ecg[(i - 'h37) / 3] >> (8 * (2 - (i - 'h37) % 3))) & 255;
    if (i == 'h40) return REV_CODE;
    if (i == 'h60) return ist;
    if (i == 'h61) return msk;
    return 0;
  endfunction

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // read and compare; last byte of a group drops its ready flag
  task automatic rdchk(int idx);
    int e, j, k;
    e = 0;
    j = idx;
    if (idx == 'h50)
    begin
      j = 0;
      for (k = 0; k < 16 && j == 0; k++)
        if ((cfg >> grp('h30 + (ptr - 'h30 + k) % 16)) & 1)
          j = 'h30 + (ptr - 'h30 + k) % 16;
      if (j != 0) e = reg_val(j);
      if (j != 0) ptr = (j == 'h3F) ? 'h30 : j + 1;
    end
    else
    begin
      e = reg_val(idx);
      ptr = 'h30;
    end
    u_bsr_host.xfer(1'b0, idx[7:0], 8'h00, 4'hF, got);
    cmp("readdata", e, got);
    if (j >= 'h31 && j <= 'h36 && (j - 'h31) % 2 == 1)
      drdy &= ~(1 << (grp(j) - 1));
    if (j >= 'h37 && j <= 'h3F && (j - 'h37) % 3 == 2)
      drdy &= ~(1 << (grp(j) - 1));
  endtask

  task automatic wr(int idx, int v);
    u_bsr_host.xfer(1'b1, idx[7:0], v[7:0], 4'hF, got);
    if (idx == 'h2F) cfg = v & 127;
    if (idx == 'h60) ist &= ~v;
    if (idx == 'h61) msk = v & 63;
    ptr = 'h30;
  endtask

  // one sample strobe, held for exactly one cycle
  task automatic strobe(int c, int e, int v);
    @(posedge mclk);
    if (e) smp.ecg[c] <= v[23:0];
    else smp.pace[c] <= v[15:0];
    if (e) smp.ecg_valid[c] <= 1'b1;
    else smp.pace_valid[c] <= 1'b1;
    @(posedge mclk);
    smp.ecg_valid <= '0;
    smp.pace_valid <= '0;
    if (e) ecg[c] = v & 'hFFFFFF;
    else pace[c] = v & 'hFFFF;
    drdy |= 1 << (c + 3 * e);
    ist |= 1 << (c + 3 * e);
  endtask

  task automatic fill_all;
    for (int c = 0; c < 6; c++) strobe(c % 3, c / 3, $random(seed));
  endtask

  // irq and alarm levels, sampled mid-cycle once settled
  // alarm output lags its input by one edge, so let one edge pass first
  task automatic lvl_chk;
    @(posedge mclk);
    @(negedge mclk);
    cmp("irq", ((ist & msk) != 0), irq);
    cmp("alarm_out_n", !alm, alarm_out_n);
  endtask

  // ========================================================================
  // closing report and hang guard
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      test_done;
    end
  end

  // main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 'h2F; i <= 'h41; i++) rdchk(i);
    wr('h40, 'hFF);
    wr('h31, 'hFF);
    // write with byte lane 0 off must leave the select register alone
    u_bsr_host.xfer(1'b1, 8'h2F, 8'h7F, 4'hE, got);
    ptr = 'h30;
    rdchk('h2F);
    rdchk('h40);
    rdchk('h50);
    alarm_active <= 1'b1;
    alm = 1;
    lvl_chk();
    strobe(0, 0, $random(seed));
    lvl_chk();
    wr('h61, 'h3F);
    lvl_chk();
    wr('h60, 'h01);
    lvl_chk();
    fill_all();
    lvl_chk();
    rdchk('h60);
    rdchk('h61);
    rdchk('h30);
    for (int i = 'h31; i <= 'h40; i++) rdchk(i);
    rdchk('h30);
    wr('h60, 'h3F);
    alarm_active <= 1'b0;
    alm = 0;
    lvl_chk();
    // loop read-back through six enable patterns, each restarted once by a direct read
    vals[5] = $random(seed) & 127;
    for (int p = 0; p < 6; p++)
    begin
      fill_all();
      wr('h2F, vals[p]);
      rdchk('h2F);
      for (int k = 0; k < 24; k++)
      begin
        if (k == 9) rdchk('h3A);
        rdchk('h50);
      end
    end
    test_done();
  end
endmodule // testbench

`default_nettype wire
